// ===== hw/pss_pkg.sv
// Package: constants, register map and types of the power sequencer
//------------------------------------------------------------------
// Contract
// R1: Raising the power-down-bar pin enables the device and starts a controlled start-up.
// R2: Lowering the pin performs an orderly shutdown, one step at a time.
// R3: Supply-ok shows the device active; low during start-up and under faults.
// R4: The sequencer starts about 40 ms after the pin goes high.
// R5: Sequence outputs 1..4 assert at 2, 4, 8, 16 ms; earlier ones stay.
// R6: Reset trigger high starts the reset delay timer, subject to under-voltage.
// R7: Under-voltage on an enabled unit holds the timer off until 500 ms.
// R8: No trigger by 500 ms starts the timer anyway and sets the timeout event.
// R9: Timer expiry drives the processor reset output high; low during start-up.
// R10: A delay capacitor fault forces full shutdown and sets the timeout event.
// R11: Active, soft sleep and deep sleep set codec, converter and regulator modes.
// R12: Power-state field: 00 active, 01 soft sleep, 10 deep, 11 reserved; resets 00.
// R13: Either sleep input forces deep sleep over the software field.
// R14: Bit 3 media, bit 2 host sleep polarity; 0 active high; reset 0.
// R15: Hibernate gives per-unit disable or low-power mode by configuration.
// R16: The system may wire sequence outputs to unit hardware-enable pins.
// R17: Tying reset trigger to sequence output 4 is recommended.
// R18: Converter in active mode: hibernate-select wins, else active-select picks active/standby.
// R19: A high hardware-enable pin enables its unit regardless of software.
// R20: Reset delay is a parameterised count; capacitor fault is an input.
// R21: Millisecond intervals count internal ticks; counters clear while the pin is low.
package pss_pkg;

  //------------------------------------------------------------------
  // Timing
  //------------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int MS_W = 10;
  localparam logic [MS_W-1:0] T_START_MS = 10'h028;
  localparam logic [MS_W-1:0] T_TIMEOUT_MS = 10'h1f4;
  localparam logic [MS_W-1:0] T_TO_LAST_MS = T_TIMEOUT_MS - 10'h001;
  localparam logic [MS_W-1:0] RST_DELAY_MS_DEF = 10'h00a;
  localparam int NUM_SEQ = 4;
  localparam logic [NUM_SEQ-1:0][MS_W-1:0] T_SEQ_MS = {10'h010, 10'h008, 10'h004, 10'h002};

  //------------------------------------------------------------------
  // Register map
  //------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_POWER_STATE_SEL = 12'h04c;
  localparam logic [ADDR_W-1:0] REG_UNIT_CFG = 12'h050;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h054;
  localparam logic [15:0] POWER_STATE_SEL_RST = 16'h0000;
  localparam logic [15:0] UNIT_CFG_RST = 16'h0f00;
  localparam int POL_MEDIA_BIT = 3;
  localparam int POL_HOST_BIT = 2;
  localparam int PS_LSB = 0;
  localparam int CFG_SWEN_LSB = 0;
  localparam int CFG_HIB_LSB = 4;
  localparam int CFG_ACT_LSB = 8;
  localparam int CFG_LP_LSB = 12;
  localparam int ST_EVT_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //------------------------------------------------------------------
  // Units and modes
  //------------------------------------------------------------------
  localparam int NUM_UNITS = 4;
  localparam int NUM_BUCKS = 2;
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_DEEP = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] UM_OFF = 2'h0;
  localparam logic [1:0] UM_STANDBY = 2'h1;
  localparam logic [1:0] UM_ACTIVE = 2'h2;
  localparam logic [1:0] UM_LOWPWR = 2'h3;
  localparam logic [1:0] CODEC_OFF = 2'h0;
  localparam logic [1:0] CODEC_HALF = 2'h1;
  localparam logic [1:0] CODEC_ON = 2'h2;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_UP = 4'h2,
    ST_SHUT = 4'h4,
    ST_HALT = 4'h8
  } pss_state_e;

endpackage

// ===== hw/pss_tick_div.sv
// Millisecond tick divider standing in for the internal oscillator
`timescale 1ns/1ps
module pss_tick_div
  import pss_pkg::*;
#(
  parameter int DIV = 4
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Tick
  output logic tick
);
  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;
  wire logic wrap = (cnt_reg == LAST);

  // Free running: the oscillator never stops, only the ms counters clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      tick <= wrap; // R21
    end
  end
endmodule

// ===== hw/pss_unit_mode.sv
// Operating mode of one converter or regulator
`timescale 1ns/1ps
module pss_unit_mode
  import pss_pkg::*;
#(
  parameter bit IS_BUCK = 1'b1
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic enable,
  input wire logic [1:0] mode,
  input wire logic hib_sel,
  input wire logic active_sel,
  input wire logic hib_lowpwr,
  // Result
  output logic [1:0] unit_mode
);
  wire logic [1:0] hib_mode = hib_lowpwr ? UM_LOWPWR : UM_OFF; // R15
  wire logic [1:0] act_mode = !IS_BUCK ? UM_ACTIVE :
                              hib_sel ? hib_mode :
                              active_sel ? UM_ACTIVE : UM_STANDBY; // R18
  wire logic [1:0] soft_mode = IS_BUCK ? UM_STANDBY : UM_ACTIVE;
  wire logic [1:0] mode_next = (!run || !enable) ? UM_OFF :
                               (mode == MODE_DEEP) ? hib_mode :
                               (mode == MODE_SOFT) ? soft_mode : act_mode; // R11

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unit_mode <= UM_OFF;
    else
      unit_mode <= mode_next;
  end
endmodule

// ===== hw/pss_power_seq.sv
// Power sequencer top: register slave, start-up FSM, reset delay, sleep modes
`timescale 1ns/1ps
module pss_power_seq
  import pss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [MS_W-1:0] RST_DELAY_MS = RST_DELAY_MS_DEF
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins in
  input wire logic power_down_bar_pin,
  input wire logic reset_trigger_in,
  input wire logic media_sleep_in,
  input wire logic host_sleep_in,
  input wire logic delay_cap_fault_in,
  input wire logic [NUM_UNITS-1:0] hw_enable_in,
  input wire logic [NUM_UNITS-1:0] under_voltage_in,
  // Device pins out
  output logic supply_ok_out,
  output logic seq_out_1,
  output logic seq_out_2,
  output logic seq_out_3,
  output logic seq_out_4,
  output logic processor_reset_bar,
  output logic delay_timeout_event,
  output logic [1:0] codec_mode,
  output logic [2*NUM_UNITS-1:0] unit_mode
);

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  pss_state_e state_reg, state_next;
  logic [MS_W-1:0] ms_cnt_reg, ms_cnt_next;
  logic [MS_W-1:0] dly_cnt_reg, dly_cnt_next;
  logic [NUM_SEQ-1:0] seq_reg, seq_next, seq_hit;
  logic dly_run_reg, trig_seen_reg, fault_reg, evt_reg;
  logic [15:0] pwr_ctl_reg, unit_cfg_reg;
  logic tick;

  pss_tick_div #(.DIV(TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  //------------------------------------------------------------------
  // Bus slave
  //------------------------------------------------------------------
  logic aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  wire logic aw_hs = s_axi_awvalid & s_axi_awready;
  wire logic w_hs = s_axi_wvalid & s_axi_wready;
  wire logic ar_hs = s_axi_arvalid & s_axi_arready;
  // Write lands one cycle after both halves are held, keeping the path short
  wire logic do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire logic aw_got_next = (aw_got_reg | aw_hs) & ~do_write;
  wire logic w_got_next = (w_got_reg | w_hs) & ~do_write;
  wire logic bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire logic rvalid_next = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire logic wr_pwr = do_write & (aw_addr_reg == REG_POWER_STATE_SEL);
  wire logic wr_cfg = do_write & (aw_addr_reg == REG_UNIT_CFG);
  wire logic wr_sts = do_write & (aw_addr_reg == REG_STATUS);
  wire logic wr_hit = wr_pwr | wr_cfg | wr_sts;
  wire logic evt_clr = wr_sts & w_strb_reg[1] & w_data_reg[ST_EVT_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      if (aw_hs)
        aw_addr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data_reg <= s_axi_wdata[15:0];
        w_strb_reg <= s_axi_wstrb[1:0];
      end
      s_axi_awready <= ~aw_got_next & ~bvalid_next;
      s_axi_wready <= ~w_got_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write)
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  //------------------------------------------------------------------
  // Control registers
  //------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_ctl_reg <= POWER_STATE_SEL_RST; // R12 R14
      unit_cfg_reg <= UNIT_CFG_RST;
    end
    else
    begin
      if (wr_pwr)
        pwr_ctl_reg <= merge16(pwr_ctl_reg, w_data_reg, w_strb_reg);
      if (wr_cfg)
        unit_cfg_reg <= merge16(unit_cfg_reg, w_data_reg, w_strb_reg);
    end
  end

  //------------------------------------------------------------------
  // Operating mode
  //------------------------------------------------------------------
  wire logic media_act = media_sleep_in ^ pwr_ctl_reg[POL_MEDIA_BIT]; // R14
  wire logic host_act = host_sleep_in ^ pwr_ctl_reg[POL_HOST_BIT]; // R14
  wire logic [1:0] sw_mode = pwr_ctl_reg[PS_LSB +: 2];
  // Reserved code falls back to active rather than an undefined mode
  wire logic [1:0] eff_mode = (media_act | host_act) ? MODE_DEEP : // R13
                              (sw_mode == MODE_RSVD) ? MODE_ACTIVE : sw_mode; // R12

  //------------------------------------------------------------------
  // Start-up sequencing and reset delay
  //------------------------------------------------------------------
  wire logic in_up = (state_reg == ST_UP);
  wire logic in_shut = (state_reg == ST_SHUT);
  wire logic pin_up = power_down_bar_pin;
  wire logic [NUM_UNITS-1:0] unit_en =
    hw_enable_in | unit_cfg_reg[CFG_SWEN_LSB +: NUM_UNITS]; // R19
  wire logic uv_any = |(under_voltage_in & unit_en);
  wire logic timeout_hit = in_up & tick & (ms_cnt_reg == T_TO_LAST_MS);
  wire logic trig_ok = reset_trigger_in & ~uv_any; // R6 R7
  wire logic dly_start = in_up & ~dly_run_reg & ~processor_reset_bar &
                         (trig_ok | timeout_hit); // R7 R8
  wire logic dly_done = dly_run_reg & (dly_cnt_reg == RST_DELAY_MS); // R20
  wire logic fault_hit = in_up & delay_cap_fault_in; // R10
  wire logic to_evt = timeout_hit & ~trig_seen_reg & ~reset_trigger_in; // R8
  wire logic evt_next = to_evt | fault_hit | (evt_reg & ~evt_clr);
  wire logic [1:0] codec_next = (!in_up || eff_mode == MODE_DEEP) ? CODEC_OFF :
                                (eff_mode == MODE_SOFT) ? CODEC_HALF : CODEC_ON; // R11

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEQ; gi++)
    begin : g_seq
      assign seq_hit[gi] = (ms_cnt_reg >= T_START_MS + T_SEQ_MS[gi]); // R4 R5
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        if (pin_up)
          state_next = ST_UP; // R1
      ST_UP:
        if (!pin_up || fault_hit)
          state_next = ST_SHUT; // R2 R10
      ST_SHUT:
        if (seq_reg == '0)
          state_next = fault_reg ? ST_HALT : ST_OFF;
      ST_HALT:
        if (!pin_up)
          state_next = ST_OFF;
      default:
        state_next = ST_OFF;
    endcase
  end

  always_comb
  begin
    seq_next = '0;
    if (in_up)
      seq_next = seq_reg | seq_hit; // R5
    else if (in_shut)
      seq_next = tick ? (seq_reg >> 1) : seq_reg; // R2
  end

  assign ms_cnt_next = (!pin_up || !in_up) ? '0 : // R21
                       (tick && ms_cnt_reg != T_TIMEOUT_MS) ? ms_cnt_reg + 1'b1 : ms_cnt_reg;
  assign dly_cnt_next = (!in_up || !dly_run_reg || dly_done) ? '0 :
                        tick ? dly_cnt_reg + 1'b1 : dly_cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_OFF;
      ms_cnt_reg <= '0;
      dly_cnt_reg <= '0;
      seq_reg <= '0;
      dly_run_reg <= 1'b0;
      trig_seen_reg <= 1'b0;
      fault_reg <= 1'b0;
      evt_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ms_cnt_reg <= ms_cnt_next;
      dly_cnt_reg <= dly_cnt_next;
      seq_reg <= seq_next;
      dly_run_reg <= in_up & ((dly_run_reg & ~dly_done) | dly_start); // R6
      trig_seen_reg <= in_up & (trig_seen_reg | reset_trigger_in);
      fault_reg <= (state_reg != ST_OFF) & (fault_reg | fault_hit);
      evt_reg <= evt_next; // R8 R10
    end
  end

  //------------------------------------------------------------------
  // Pin outputs
  //------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      processor_reset_bar <= 1'b0;
      supply_ok_out <= 1'b0;
      codec_mode <= CODEC_OFF;
    end
    else
    begin
      processor_reset_bar <= in_up & pin_up & ~delay_cap_fault_in &
                             (processor_reset_bar | dly_done); // R9
      supply_ok_out <= in_up & pin_up & ~delay_cap_fault_in & seq_reg[NUM_SEQ-1] &
                       processor_reset_bar & ~uv_any; // R3
      codec_mode <= codec_next;
    end
  end

  assign seq_out_1 = seq_reg[0];
  assign seq_out_2 = seq_reg[1];
  assign seq_out_3 = seq_reg[2];
  assign seq_out_4 = seq_reg[3];
  assign delay_timeout_event = evt_reg;

  // Units stay powered through shutdown until the sequence outputs drain
  generate
    for (gi = 0; gi < NUM_UNITS; gi++)
    begin : g_unit
      pss_unit_mode #(.IS_BUCK(gi < NUM_BUCKS)) u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(in_up | in_shut),
        .enable(unit_en[gi]),
        .mode(eff_mode),
        .hib_sel(unit_cfg_reg[CFG_HIB_LSB + gi]),
        .active_sel(unit_cfg_reg[CFG_ACT_LSB + gi]),
        .hib_lowpwr(unit_cfg_reg[CFG_LP_LSB + gi]),
        .unit_mode(unit_mode[2*gi +: 2])
      );
    end
  endgenerate

  //------------------------------------------------------------------
  // Register reads
  //------------------------------------------------------------------
  wire logic [15:0] status_word = {unit_en, 2'h0, fault_reg, evt_reg, eff_mode,
                                   seq_reg, processor_reset_bar, supply_ok_out};
  wire logic rd_hit = (s_axi_araddr == REG_POWER_STATE_SEL) ||
                      (s_axi_araddr == REG_UNIT_CFG) || (s_axi_araddr == REG_STATUS);
  wire logic [15:0] rd_word = (s_axi_araddr == REG_POWER_STATE_SEL) ? pwr_ctl_reg :
                              (s_axi_araddr == REG_UNIT_CFG) ? unit_cfg_reg :
                              (s_axi_araddr == REG_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_hs)
      begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_running;
    in_up && pin_up && !delay_cap_fault_in;
  endsequence

  sequence s_seq1_due;
    s_running ##0 (ms_cnt_reg >= T_START_MS + T_SEQ_MS[0]);
  endsequence

  seq_order_a: assert property (
    (seq_out_2 |-> seq_out_1) and (seq_out_3 |-> seq_out_2) and (seq_out_4 |-> seq_out_3))
    else $error("sequence outputs out of order"); // R5

  seq_first_a: assert property (s_seq1_due |=> seq_out_1)
    else $error("first sequence output late"); // R5

  seq_early_a: assert property (
    (in_up && ms_cnt_reg < T_START_MS + T_SEQ_MS[0]) |=> !seq_out_1 || !in_up || $past(in_shut))
    else $error("first sequence output early"); // R4

  pd_shut_a: assert property (
    (in_up && !pin_up) |=> in_shut && !processor_reset_bar && !supply_ok_out)
    else $error("power-down did not shut down"); // R2

  shut_step_a: assert property (
    (in_shut && seq_out_4 && tick) |=> !seq_out_4 && seq_out_3)
    else $error("shutdown skipped a step"); // R2

  ok_startup_a: assert property (!seq_out_4 |-> !supply_ok_out)
    else $error("supply ok during start-up"); // R3

  rst_release_a: assert property (
    $rose(processor_reset_bar) |-> $past(dly_run_reg) && $past(dly_cnt_reg) == RST_DELAY_MS)
    else $error("processor reset released early"); // R9

  uv_hold_a: assert property (
    (in_up && !dly_run_reg && !processor_reset_bar && uv_any && !timeout_hit) |=> !dly_run_reg)
    else $error("delay started under voltage"); // R7

  timeout_evt_a: assert property (
    (timeout_hit && !trig_seen_reg && !reset_trigger_in) |=> delay_timeout_event && dly_run_reg)
    else $error("timeout did not start delay"); // R8

  fault_shut_a: assert property (
    (in_up && delay_cap_fault_in) |=> in_shut && delay_timeout_event && !processor_reset_bar)
    else $error("capacitor fault not handled"); // R10

  deep_sleep_a: assert property (
    (in_up && (media_act || host_act)) |=> codec_mode == CODEC_OFF)
    else $error("sleep input did not force deep sleep"); // R13

  bresp_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule

// ===== testbench/pss_far_side.sv
// Far-side model: enable pins, reset trigger and supply monitors
`timescale 1ns/1ps
module pss_far_side
(
  // Sequencer outputs
  input wire logic [3:0] seq,
  // Scenario controls
  input wire logic trig_off,
  input wire logic uv_on,
  // Pins into the device
  output logic [3:0] hw_en,
  output logic trig,
  output logic [3:0] uv
);
  assign hw_en = seq;
  assign trig = seq[3] && !trig_off;
  // A monitor only flags a supply that is enabled
  assign uv = uv_on ? (hw_en & 4'h1) : 4'h0;
endmodule

// ===== testbench/pss_power_seq_tb.sv
// Testbench top: bus, start-up, sleep modes, shutdown, fault, timeout
`timescale 1ns/1ps
module pss_power_seq_tb;
  import pss_pkg::*;
  //------------------------------------------------------------------
  // Signals
  //------------------------------------------------------------------
  localparam int TCK = 4;
  localparam int RD = 3;
  localparam logic [1:0] CM [4] = '{CODEC_ON, CODEC_HALF, CODEC_OFF, CODEC_ON};
  localparam logic [7:0] UM [4] = '{8'haa, 8'ha5, 8'h00, 8'haa};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pin = 1'b0, msl = 1'b0, hsl = 1'b0, fault = 1'b0, trig_off = 1'b0, uv_on = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trig, sok, rstb, evt;
  logic [1:0] bresp, rresp, codec;
  logic [31:0] rdata;
  logic [3:0] seq, hwen, uv;
  logic [7:0] umode;
  logic [7:0] lfsr = 8'h4c;
  logic [33:0] notes [$];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0 = 0;
  int rise [6];
  wire [5:0] mon = {sok, rstb, seq};

  initial
  begin
    forever #25 aclk = ~aclk;
  end

  pss_power_seq #(.TICK_CYCLES(TCK), .RST_DELAY_MS(10'(RD))) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_down_bar_pin(pin), .reset_trigger_in(trig), .media_sleep_in(msl),
    .host_sleep_in(hsl), .delay_cap_fault_in(fault), .hw_enable_in(hwen),
    .under_voltage_in(uv), .supply_ok_out(sok), .seq_out_1(seq[0]),
    .seq_out_2(seq[1]), .seq_out_3(seq[2]), .seq_out_4(seq[3]),
    .processor_reset_bar(rstb), .delay_timeout_event(evt), .codec_mode(codec),
    .unit_mode(umode));

  pss_far_side far (.seq(seq), .trig_off(trig_off), .uv_on(uv_on), .hw_en(hwen),
    .trig(trig), .uv(uv));

  //------------------------------------------------------------------
  // Tasks
  //------------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    notes.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 100);
    if (!bvalid)
      failures++;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n = 0;
    notes.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 100);
    if (!rvalid)
      failures++;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic power_up(input int k, input int lim);
    int n = 0;
    rise = '{default: 0};
    t0 = cyc;
    pin <= 1'b1;
    while (!mon[k] && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    if (!mon[k])
      failures++;
    repeat (2) @(posedge aclk);
  endtask

  //------------------------------------------------------------------
  // Response watcher, rise stamps and hang limit
  //------------------------------------------------------------------
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++)
      if (mon[i] === 1'b1 && rise[i] == 0)
        rise[i] <= cyc - t0;
    if (bvalid && bready)
      chk("bresp", notes.pop_front(), {bresp, 32'h0});
    if (rvalid && rready)
      chk("read", notes.pop_front(), {rresp, rdata});
    if (cyc > 12000)
    begin
      failures++;
      print_verdict();
    end
  end

  //------------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(REG_POWER_STATE_SEL, {RESP_OKAY, 32'h0});
    rd(12'h058, {RESP_SLVERR, 32'h0});
    wr(12'h05a, 32'h1, RESP_SLVERR);
    power_up(5, 400);
    for (int i = 0; i < 4; i++)
      chk("seq", 34'h1, 34'(rise[i] >= TCK * (38 + (2 << i)) && rise[i] <= TCK * (42 + (2 << i))));
    chk("rstb", 34'h1, 34'(rise[4] >= rise[3] + TCK * RD - 4 && rise[4] <= rise[3] + TCK * RD + 8));
    chk("sok", 34'h1, 34'(rise[5] - rise[4]));
    chk("evt", 34'h0, 34'(evt));
    for (int m = 0; m < 4; m++)
    begin
      wr(REG_POWER_STATE_SEL, 32'(m), RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("codec", 34'(CM[m]), 34'(codec));
      chk("units", 34'(UM[m]), 34'(umode));
    end
    // Buck 0 hibernate low-power, buck 1 standby, LDO 0 low-power in hibernate
    wr(REG_UNIT_CFG, 32'h5d10, RESP_OKAY);
    rd(REG_UNIT_CFG, {RESP_OKAY, 32'h5d10});
    repeat (3) @(posedge aclk);
    chk("ucfg", 34'ha7, 34'(umode));
    for (int k = 0; k < 3; k++)
    begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      wr(REG_POWER_STATE_SEL, {28'h0, lfsr[3:2], 2'h0}, RESP_OKAY);
      rd(REG_POWER_STATE_SEL, {RESP_OKAY, 28'h0, lfsr[3:2], 2'h0});
      chk("pol", 34'((lfsr[3:2] != 2'h0) ? CODEC_OFF : CODEC_ON), 34'(codec));
    end
    wr(REG_POWER_STATE_SEL, 32'h0, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      msl <= (k == 0);
      hsl <= (k == 1);
      repeat (3) @(posedge aclk);
      chk("sleep", 34'(CODEC_OFF), 34'(codec));
      chk("hib", 34'h33, 34'(umode));
    end
    msl <= 1'b0;
    hsl <= 1'b0;
    repeat (3) @(posedge aclk);
    pin <= 1'b0;
    // Codec drops one edge after the shutdown state is entered
    repeat (3) @(posedge aclk);
    chk("shut", 34'h4, 34'({sok, rstb, seq[0], codec}));
    repeat (40) @(posedge aclk);
    chk("off", 34'h0, 34'({seq, umode}));
    power_up(5, 400);
    fault <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("fault", 34'h1, 34'({sok, rstb, evt}));
    fault <= 1'b0;
    pin <= 1'b0;
    repeat (40) @(posedge aclk);
    wr(REG_STATUS, 32'h100, RESP_OKAY);
    for (int m = 0; m < 2; m++)
    begin
      trig_off <= m[0];
      uv_on <= !m[0];
      power_up(4, 2400);
      chk("late", 34'h1, 34'(rise[4] >= TCK * (500 + RD) - 8 && rise[4] <= TCK * (500 + RD) + 8));
      chk("tevt", 34'(m), 34'(evt));
      chk("uvsok", 34'(m), 34'(sok));
      pin <= 1'b0;
      repeat (40) @(posedge aclk);
    end
    print_verdict();
  end
endmodule
